// *** include/dpsc_defines.vh ***
`ifndef DPSC_DEFINES_VH
`define DPSC_DEFINES_VH

// ****************************************
// operating states
// ****************************************
`define DPSC_ST_FREE_RUN 2'h0
`define DPSC_ST_ACQUIRE  2'h1
`define DPSC_ST_LOCKED   2'h2
`define DPSC_ST_HOLDOVER 2'h3

// ****************************************
// word widths
// ****************************************
`define DPSC_NUM_W   40
`define DPSC_STEP_W  38

// ****************************************
// timing
// ****************************************
`define DPSC_CLK_PERIOD_NS 40
`define DPSC_TRIG_MIN_PULSE_NS 100
`define DPSC_ACQ_WIDE_CYCLES 16'h0400
`define DPSC_ANALOG_STEP_DEFAULT 40'h0000010000

// ****************************************
// reset values
// ****************************************
`define DPSC_NUM_RESET 40'h0000000000

`endif

// *** logic/dpsc_edge_sync.v ***
`timescale 1ns/1ps

// two-flop synchroniser with rising edge pulse; edge taken between stages two and three
module dpsc_edge_sync
(
	input  wire core_clk,
	input  wire rst_b,
	input  wire pin_in,
	output wire level_out,
	output wire rise_pulse
);
	reg meta_q;
	reg sync_q;
	reg last_q;

	// ****************************************
	// synchroniser
	// ****************************************
	// first stage read only by the second stage
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level_out  = sync_q;
	assign rise_pulse = sync_q & ~last_q;
endmodule

// *** logic/dpsc_analog_loop_feeder.v ***
`timescale 1ns/1ps
`include "dpsc_defines.vh"

// feeds a signed offset into the analog numerator in bounded steps
module dpsc_analog_feeder
(
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        load_pulse,
	input  wire [39:0] target_word,
	input  wire [39:0] step_size,
	output reg  [39:0] applied_q,
	output reg         done_q
);
	reg  [39:0] remain_q;
	wire        neg;
	wire [39:0] mag;
	wire [39:0] take;

	assign neg  = remain_q[39];
	assign mag  = neg ? (~remain_q + 40'h0000000001) : remain_q;
	assign take = (mag > step_size) ? step_size : mag;

	// ****************************************
	// stepping
	// ****************************************
	// a new load drops whatever was still pending
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			remain_q  <= `DPSC_NUM_RESET;
			applied_q <= `DPSC_NUM_RESET;
			done_q    <= 1'b1;
		end
		else if (load_pulse)
		begin
			remain_q <= target_word;
			done_q   <= 1'b0;
		end
		else if (remain_q != 40'h0000000000)
		begin
			if (neg)
			begin
				applied_q <= applied_q - take;
				remain_q  <= remain_q + take;
			end
			else
			begin
				applied_q <= applied_q + take;
				remain_q  <= remain_q - take;
			end
		end
		else
		begin
			done_q <= 1'b1; // fully fed
		end
	end
endmodule

// *** logic/dpsc_core.v ***
`timescale 1ns/1ps
`include "dpsc_defines.vh"

// What this block does
// - after configuration, free-run with analog loop on crystal once crystal is valid
// - reference lost with history enabled but not valid goes to free-run, not holdover
// - any valid reference leaves free-run or holdover into lock acquisition
// - wide bandwidth during acquisition, normal bandwidth once acquired
// - frequency and phase lock loss flags appear on status outputs
// - frequency lock gained in locked state with history enabled starts history accumulation
// - reference lost with no valid input enters holdover from lock unless history is enabled but not valid, or from acquisition only with valid history
// - history disabled: holdover uses signed free-run word on digital numerator
// - history enabled uses history if valid, else the free-run word
// - entering holdover sets phase lock lost flag
// - frequency lock lost flag frozen during holdover
// - valid input during holdover leaves holdover and relocks without glitch
// - steering hits digital numerator when locked, analog numerator in free-run and holdover
// - each relative step adds or subtracts the 38-bit step word
// - update bit write steps once: 0 raises, 1 lowers frequency
// - trigger pin rising edge steps once; direction pin 0 up, 1 down
// - clearing steer enable drops offset and restores programmed numerator
// - step word 0 to 2^38-1; denominator 0 means 2^40
// - history enable 1: relative analog steps; 0: direct analog word, readable
// - free-run word is signed two's complement 40-bit
// - new free-run write drops remaining analog steps
// - completion flag once free-run word fully fed in
module dpsc_core
(
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        loop_soft_reset,
	input  wire        crystal_oscillator_input_valid,
	input  wire        ref_valid_pin,
	input  wire        freq_lock_det,
	input  wire        phase_lock_det,
	input  wire        acquire_done,
	input  wire        history_enable,
	input  wire        history_valid,
	input  wire [39:0] history_word,
	input  wire [39:0] holdover_tuning_word,
	input  wire        holdover_word_wr,
	input  wire [39:0] analog_step_size,
	input  wire [39:0] loop_feedback_numerator,
	input  wire        fb_num_wr,
	input  wire [39:0] loop_denominator,
	input  wire [39:0] analog_numerator_base,
	input  wire        steer_enable,
	input  wire [37:0] steer_step_word,
	input  wire        steer_update_wr,
	input  wire        steer_update_bit,
	input  wire        pin_control_sel,
	input  wire        steer_trigger_pin,
	input  wire        steer_direction_pin,
	output reg  [1:0]  loop_state_q,
	output reg         analog_on_crystal_q,
	output reg         wide_bandwidth_q,
	output reg         freq_lock_lost_flag,
	output reg         phase_lock_lost_flag,
	output reg         history_accumulate_q,
	output reg  [39:0] effective_digital_numerator,
	output reg  [40:0] effective_denominator,
	output reg  [39:0] effective_analog_numerator,
	output wire        analog_feed_done,
	output reg         holdover_from_history_q
);
	// ****************************************
	// declarations
	// ****************************************
	reg  [1:0]  state_d;
	reg  [39:0] steer_offset_q;
	reg  [39:0] fb_prog_q;
	reg  [39:0] holdover_word_q;
	reg         hist_valid_q;
	reg         ref_seen_q;
	wire        ref_valid;
	wire        trig_rise;
	wire        dir_level;
	wire        step_req;
	wire        step_down;
	wire [39:0] fed_offset;

	// sign-aware add of a 38-bit step to a 40-bit word
	function [39:0] apply_step;
		input [39:0] base;
		input [37:0] step;
		input        down;
		begin
			if (down)
				apply_step = base - {2'b00, step};
			else
				apply_step = base + {2'b00, step};
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	dpsc_edge_sync u_ref_sync
	(
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (ref_valid_pin),
		.level_out  (ref_valid),
		.rise_pulse ()
	);

	// trigger relies on the external pulse lasting over 100 ns
	dpsc_edge_sync u_trig_sync
	(
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (steer_trigger_pin),
		.level_out  (),
		.rise_pulse (trig_rise)
	);

	dpsc_edge_sync u_dir_sync
	(
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (steer_direction_pin),
		.level_out  (dir_level),
		.rise_pulse ()
	);

	// ****************************************
	// state machine
	// ****************************************
	// next state from reference and lock status
	always @*
	begin
		state_d = loop_state_q;
		case (loop_state_q)
			`DPSC_ST_FREE_RUN:
			begin
				if (ref_valid)
					state_d = `DPSC_ST_ACQUIRE;
			end
			`DPSC_ST_ACQUIRE:
			begin
				if (!ref_valid)
					state_d = hist_valid_q ? `DPSC_ST_HOLDOVER : `DPSC_ST_FREE_RUN;
				else if (acquire_done)
					state_d = `DPSC_ST_LOCKED;
			end
			`DPSC_ST_LOCKED:
			begin
				if (!ref_valid)
					// history enabled but not valid means free-run, else holdover once ref_seen_q is set
					state_d = (history_enable && hist_valid_q) || !history_enable ?
						(ref_seen_q ? `DPSC_ST_HOLDOVER : `DPSC_ST_FREE_RUN) :
						`DPSC_ST_FREE_RUN;
			end
			`DPSC_ST_HOLDOVER:
			begin
				if (ref_valid)
					state_d = `DPSC_ST_ACQUIRE; // hitless relock
			end
			default:
			begin
				state_d = `DPSC_ST_FREE_RUN;
			end
		endcase
	end

	// state register; soft reset also lands in free-run
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			loop_state_q <= `DPSC_ST_FREE_RUN;
		else if (loop_soft_reset)
			loop_state_q <= `DPSC_ST_FREE_RUN;
		else
			loop_state_q <= state_d;
	end

	// ****************************************
	// status and bandwidth
	// ****************************************
	// analog loop follows crystal only in free-run, wide loop only while acquiring
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			analog_on_crystal_q     <= 1'b0;
			wide_bandwidth_q        <= 1'b0;
			ref_seen_q              <= 1'b0;
			holdover_from_history_q <= 1'b0;
		end
		else
		begin
			analog_on_crystal_q <= crystal_oscillator_input_valid &&
				(state_d == `DPSC_ST_FREE_RUN);
			wide_bandwidth_q <= (state_d == `DPSC_ST_ACQUIRE);
			if (loop_state_q == `DPSC_ST_LOCKED)
				ref_seen_q <= 1'b1;
			else if (loop_state_q == `DPSC_ST_FREE_RUN)
				ref_seen_q <= 1'b0;
			// holdover source: history if valid, free-run word otherwise
			if (state_d == `DPSC_ST_HOLDOVER && loop_state_q != `DPSC_ST_HOLDOVER)
				holdover_from_history_q <= history_enable && hist_valid_q;
		end
	end

	// lock flags; phase loss forced on holdover entry, freq loss frozen
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			freq_lock_lost_flag  <= 1'b1;
			phase_lock_lost_flag <= 1'b1;
		end
		else
		begin
			if (state_d == `DPSC_ST_HOLDOVER)
				phase_lock_lost_flag <= 1'b1;
			else
				phase_lock_lost_flag <= ~phase_lock_det;
			if (loop_state_q != `DPSC_ST_HOLDOVER || ref_valid)
				freq_lock_lost_flag <= ~freq_lock_det;
		end
	end

	// history accumulates once locked, frequency lock held and enabled
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			history_accumulate_q <= 1'b0;
			hist_valid_q         <= 1'b0;
		end
		else
		begin
			history_accumulate_q <= history_enable && !freq_lock_lost_flag &&
				(loop_state_q == `DPSC_ST_LOCKED);
			hist_valid_q <= history_enable && history_valid;
		end
	end

	// ****************************************
	// digital loop steering
	// ****************************************
	assign step_req  = pin_control_sel ? trig_rise : steer_update_wr;
	assign step_down = pin_control_sel ? dir_level : steer_update_bit;

	// offset accumulates while enabled and locked, cleared when disabled
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			steer_offset_q <= `DPSC_NUM_RESET;
			fb_prog_q      <= `DPSC_NUM_RESET;
		end
		else
		begin
			if (fb_num_wr)
				fb_prog_q <= loop_feedback_numerator; // absolute write
			if (!steer_enable)
				steer_offset_q <= `DPSC_NUM_RESET;
			else if (fb_num_wr)
				steer_offset_q <= `DPSC_NUM_RESET;
			else if (step_req && loop_state_q == `DPSC_ST_LOCKED)
				steer_offset_q <= apply_step(steer_offset_q, steer_step_word, step_down);
		end
	end

	// ****************************************
	// numerators
	// ****************************************
	// free-run word captured as signed value
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			holdover_word_q <= `DPSC_NUM_RESET;
		else if (holdover_word_wr)
			holdover_word_q <= holdover_tuning_word;
	end

	dpsc_analog_feeder u_feeder
	(
		.core_clk    (core_clk),
		.rst_b       (rst_b),
		.load_pulse  (holdover_word_wr && history_enable),
		.target_word (holdover_tuning_word),
		.step_size   (analog_step_size),
		.applied_q   (fed_offset),
		.done_q      (analog_feed_done)
	);

	// effective values; holdover picks history or free-run word
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			effective_digital_numerator <= `DPSC_NUM_RESET;
			effective_analog_numerator  <= `DPSC_NUM_RESET;
			effective_denominator       <= 41'h00000000000;
		end
		else
		begin
			// zero denominator stands for 2^40
			effective_denominator <= (loop_denominator == 40'h0000000000) ?
				41'h10000000000 : {1'b0, loop_denominator};
			if (loop_state_q == `DPSC_ST_HOLDOVER)
				effective_digital_numerator <= holdover_from_history_q ?
					history_word : fb_prog_q + holdover_word_q;
			else
				effective_digital_numerator <= fb_prog_q + steer_offset_q;
			// analog numerator steered in free-run and holdover, relative or direct
			if (loop_state_q == `DPSC_ST_LOCKED || loop_state_q == `DPSC_ST_ACQUIRE)
				effective_analog_numerator <= analog_numerator_base;
			else if (history_enable)
				effective_analog_numerator <= analog_numerator_base + fed_offset;
			else
				effective_analog_numerator <= analog_numerator_base + holdover_word_q;
		end
	end
endmodule

// *** sim/dpsc_core_properties.sv ***
`timescale 1ns/1ps
`include "dpsc_defines.vh"

// ****
// core checker
// ****
module dpsc_core_properties
(
	input wire        core_clk,
	input wire        rst_b,
	input wire        loop_soft_reset,
	input wire        ref_valid_pin,
	input wire        history_enable,
	input wire        history_valid,
	input wire [39:0] loop_feedback_numerator,
	input wire        fb_num_wr,
	input wire        steer_enable,
	input wire [37:0] steer_step_word,
	input wire        steer_update_wr,
	input wire        steer_update_bit,
	input wire        pin_control_sel,
	input wire [1:0]  loop_state_q,
	input wire        wide_bandwidth_q,
	input wire        freq_lock_lost_flag,
	input wire        phase_lock_lost_flag,
	input wire [39:0] effective_digital_numerator
);
	// a step is judged only while nothing else moves the numerator
	wire        lk = loop_state_q == `DPSC_ST_LOCKED;
	wire        ho = loop_state_q == `DPSC_ST_HOLDOVER;
	wire        qt = lk && steer_enable && !fb_num_wr && !pin_control_sel;
	wire [39:0] dn = effective_digital_numerator;
	wire [39:0] st = steer_update_bit ? -{2'h0, steer_step_word} : {2'h0, steer_step_word};

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	soft_free_a: assert property (loop_soft_reset |=> loop_state_q == `DPSC_ST_FREE_RUN)
		else $error("soft reset ignored");
	ref_acquire_a: assert property ((ref_valid_pin && !loop_soft_reset) [*5] |->
		loop_state_q != `DPSC_ST_FREE_RUN) else $error("valid reference ignored");
	locked_bw_a: assert property (lk [*2] |-> !wide_bandwidth_q)
		else $error("wide bandwidth while locked");
	hold_phase_a: assert property (ho [*2] |-> phase_lock_lost_flag)
		else $error("phase flag low in holdover");
	hold_freq_a: assert property (ho [*2] |-> $stable(freq_lock_lost_flag))
		else $error("frequency flag moved in holdover");
	no_history_a: assert property (lk && history_enable && !history_valid |=> !ho)
		else $error("holdover without history");
	step_apply_a: assert property (qt && steer_update_wr ##1 qt && !steer_update_wr |=>
		!lk || dn == $past(dn) + $past(st, 2)) else $error("step not applied");
	steer_off_a: assert property ((lk && !steer_enable && !fb_num_wr) [*3] |->
		dn == loop_feedback_numerator) else $error("offset not cleared");
endmodule

bind dpsc_core dpsc_core_properties i_dpsc_core_properties
(
	.core_clk, .rst_b, .loop_soft_reset, .ref_valid_pin, .history_enable, .history_valid,
	.loop_feedback_numerator, .fb_num_wr, .steer_enable, .steer_step_word, .steer_update_wr,
	.steer_update_bit, .pin_control_sel, .loop_state_q, .wide_bandwidth_q,
	.freq_lock_lost_flag, .phase_lock_lost_flag, .effective_digital_numerator
);

// *** sim/dpsc_partner.sv ***
`timescale 1ns/1ps

// ****
// reference, crystal and step pins
// ****
module dpsc_partner
(
	input  wire core_clk,
	input  wire ref_on,
	input  wire step_go,
	input  wire step_dn,
	output reg  crystal_oscillator_input_valid,
	output reg  ref_valid_pin,
	output reg  steer_trigger_pin,
	output reg  steer_direction_pin
);
	reg [2:0] cnt_q;

	// quiet pins at time zero, crystal already good
	initial
	begin
		crystal_oscillator_input_valid = 1'b1;
		ref_valid_pin = 1'b0;
		steer_trigger_pin = 1'b0;
		steer_direction_pin = 1'b0;
		cnt_q = 3'h0;
	end

	// trigger high 3 cycles, period 7: 120 ns pulses, under 5 MHz
	always @(posedge core_clk)
	begin
		ref_valid_pin <= ref_on;
		steer_trigger_pin <= (cnt_q > 3'h3);
		if (cnt_q != 3'h0)
			cnt_q <= cnt_q - 3'h1;
		else if (step_go)
		begin
			cnt_q <= 3'h6;
			steer_direction_pin <= step_dn; // settles a cycle before the edge
		end
	end
endmodule

// *** sim/dpsc_core_tb_top.sv ***
`timescale 1ns/1ps
`include "dpsc_defines.vh"

module dpsc_core_tb_top;
	reg         core_clk, rst_b, loop_soft_reset, freq_lock_det, phase_lock_det, acquire_done;
	reg         history_enable, history_valid, holdover_word_wr, fb_num_wr, steer_enable;
	reg         steer_update_wr, steer_update_bit, pin_control_sel, ref_on, step_go, step_dn;
	reg  [37:0] steer_step_word;
	reg  [39:0] history_word, holdover_tuning_word, analog_step_size, loop_feedback_numerator;
	reg  [39:0] loop_denominator, analog_numerator_base;
	wire        crystal_oscillator_input_valid, ref_valid_pin, steer_trigger_pin;
	wire        steer_direction_pin, analog_on_crystal_q, wide_bandwidth_q;
	wire        freq_lock_lost_flag, phase_lock_lost_flag, history_accumulate_q;
	wire        analog_feed_done, holdover_from_history_q;
	wire [1:0]  loop_state_q;
	wire [39:0] effective_digital_numerator, effective_analog_numerator;
	wire [40:0] effective_denominator;
	integer     err_count, num_checks, cyc;
	localparam  [39:0] N0 = 40'h123456789A;
	localparam  [39:0] B0 = 40'h0001000000;
	localparam  [39:0] HW = 40'h00ABCDEF00;

	dpsc_core i_dpsc_core
	(
		.core_clk, .rst_b, .loop_soft_reset, .crystal_oscillator_input_valid, .ref_valid_pin,
		.freq_lock_det, .phase_lock_det, .acquire_done, .history_enable, .history_valid,
		.history_word, .holdover_tuning_word, .holdover_word_wr, .analog_step_size,
		.loop_feedback_numerator, .fb_num_wr, .loop_denominator, .analog_numerator_base,
		.steer_enable, .steer_step_word, .steer_update_wr, .steer_update_bit,
		.pin_control_sel, .steer_trigger_pin, .steer_direction_pin, .loop_state_q,
		.analog_on_crystal_q, .wide_bandwidth_q, .freq_lock_lost_flag, .phase_lock_lost_flag,
		.history_accumulate_q, .effective_digital_numerator, .effective_denominator,
		.effective_analog_numerator, .analog_feed_done, .holdover_from_history_q
	);

	dpsc_partner i_dpsc_partner
	(
		.core_clk, .ref_on, .step_go, .step_dn, .crystal_oscillator_input_valid,
		.ref_valid_pin, .steer_trigger_pin, .steer_direction_pin
	);

	// ****
	// clock, watchdog, helpers
	// ****
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// run needs under 1000 cycles
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			err_count = err_count + 1;
			summarize();
		end
	end

	task summarize();
	begin
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	task chk_num(input [40:0] got, input [40:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask

	task chk_bit(input got, input exp);
		chk_num({40'h0, got}, {40'h0, exp});
	endtask

	task tick(input integer n);
		repeat (n) @(negedge core_clk);
	endtask

	task wait_st(input [1:0] s);
		integer i;
	begin
		for (i = 0; i < 60 && loop_state_q !== s; i = i + 1)
			tick(1);
		chk_num({39'h0, loop_state_q}, {39'h0, s});
	end
	endtask

	// strobes last one cycle, then settle
	task upd(input d);
	begin
		steer_update_bit = d;
		steer_update_wr = 1'b1;
		tick(1);
		steer_update_wr = 1'b0;
		tick(4);
	end
	endtask

	task pin_step(input d);
	begin
		step_dn = d;
		step_go = 1'b1;
		tick(1);
		step_go = 1'b0;
		tick(12);
	end
	endtask

	task put_word(input [39:0] w);
	begin
		holdover_tuning_word = w;
		holdover_word_wr = 1'b1;
		tick(1);
		holdover_word_wr = 1'b0;
	end
	endtask

	// ****
	// scenarios
	// ****
	task t_reset();
	begin
		tick(2);
		wait_st(`DPSC_ST_FREE_RUN);
		chk_bit(analog_on_crystal_q, 1'b1);
		chk_bit(freq_lock_lost_flag, 1'b1);
		$display("test reset done");
	end
	endtask

	task t_lock();
	begin
		history_enable = 1'b1;
		ref_on = 1'b1;
		wait_st(`DPSC_ST_ACQUIRE);
		chk_bit(wide_bandwidth_q, 1'b1);
		{freq_lock_det, phase_lock_det, acquire_done} = 3'h7;
		wait_st(`DPSC_ST_LOCKED);
		tick(3);
		chk_bit(wide_bandwidth_q, 1'b0);
		chk_bit(phase_lock_lost_flag, 1'b0);
		chk_bit(history_accumulate_q, 1'b1);
		chk_num(effective_denominator, 41'h10000000000);
		$display("test lock done");
	end
	endtask

	task t_steer();
	begin
		loop_feedback_numerator = N0;
		fb_num_wr = 1'b1;
		tick(1);
		fb_num_wr = 1'b0;
		steer_enable = 1'b1;
		steer_step_word = 38'h3FFFFFFFFF;
		upd(1'b0);
		chk_num({1'b0, effective_digital_numerator}, {1'b0, N0 + 40'h3FFFFFFFFF});
		upd(1'b1);
		chk_num({1'b0, effective_digital_numerator}, {1'b0, N0});
		pin_control_sel = 1'b1;
		steer_step_word = 38'h0000000100;
		pin_step(1'b1);
		chk_num({1'b0, effective_digital_numerator}, {1'b0, N0 - 40'h100});
		pin_step(1'b0);
		pin_step(1'b0);
		chk_num({1'b0, effective_digital_numerator}, {1'b0, N0 + 40'h100});
		steer_enable = 1'b0;
		pin_control_sel = 1'b0;
		tick(4);
		chk_num({1'b0, effective_digital_numerator}, {1'b0, N0});
		$display("test steer done");
	end
	endtask

	// h picks free-run word or stored history as the holdover source
	task t_hold(input h);
	begin
		{history_enable, history_valid} = {h, h};
		if (!h)
			put_word(40'hFFFFFFFF00);
		ref_on = 1'b0;
		wait_st(`DPSC_ST_HOLDOVER);
		chk_bit(phase_lock_lost_flag, 1'b1);
		chk_bit(holdover_from_history_q, h);
		// detector drops only once in holdover, so the flag must stay frozen
		freq_lock_det = 1'b0;
		tick(2);
		chk_bit(freq_lock_lost_flag, 1'b0);
		chk_num({1'b0, effective_digital_numerator}, {1'b0, h ? HW : N0 - 40'h100});
		chk_num({1'b0, effective_analog_numerator}, {1'b0, h ? B0 : B0 - 40'h100});
		{ref_on, freq_lock_det} = 2'h3;
		wait_st(`DPSC_ST_LOCKED);
		tick(3);
		$display("test holdover done");
	end
	endtask

	task t_free();
	begin
		{history_valid, acquire_done, ref_on} = 3'h0;
		wait_st(`DPSC_ST_FREE_RUN);
		ref_on = 1'b1;
		wait_st(`DPSC_ST_ACQUIRE);
		{loop_soft_reset, ref_on} = 2'h2;
		tick(4);
		loop_soft_reset = 1'b0;
		wait_st(`DPSC_ST_FREE_RUN);
		$display("test free-run done");
	end
	endtask

	// second word lands after two steps; steps already fed stay applied
	task t_feed();
		integer i;
	begin
		history_enable = 1'b1;
		put_word(40'h0000001000);
		tick(2);
		put_word(40'hFFFFFFFFC0);
		for (i = 0; i < 200 && analog_feed_done !== 1'b1; i = i + 1)
			tick(1);
		chk_bit(analog_feed_done, 1'b1);
		chk_num({1'b0, effective_analog_numerator}, {1'b0, B0 - 40'h20});
		history_enable = 1'b0;
		put_word(40'h0000000020);
		tick(4);
		chk_num({1'b0, effective_analog_numerator}, {1'b0, B0 + 40'h20});
		$display("test feed done");
	end
	endtask

	initial
	begin
		{loop_soft_reset, freq_lock_det, phase_lock_det, acquire_done, history_enable} = 5'h0;
		{history_valid, holdover_word_wr, fb_num_wr, steer_enable, steer_update_wr} = 5'h0;
		{steer_update_bit, pin_control_sel, ref_on, step_go, step_dn} = 5'h0;
		{steer_step_word, history_word, holdover_tuning_word} = 118'h0;
		history_word = HW;
		{loop_feedback_numerator, loop_denominator} = 80'h0;
		analog_step_size = 40'h0000000010;
		analog_numerator_base = B0;
		{err_count, num_checks, cyc} = 96'h0;
		rst_b = 1'b0;
		tick(16);
		rst_b = 1'b1;
		t_reset();
		t_lock();
		t_steer();
		t_hold(1'b0);
		t_hold(1'b1);
		t_free();
		t_feed();
		summarize();
	end
endmodule
